// ---- rtl/bp_pkg.sv ----
// package: register map, reset values and field layout of the io port bank
package bp_pkg;
   localparam int unsigned BP_WIDTH     = 8;
   localparam int unsigned BP_ADDR_W    = 4;
   // register indices on the plain register port
   localparam logic [3:0] BP_OFS_PIN_LEVEL  = 4'h0;
   localparam logic [3:0] BP_OFS_DIRECTION  = 4'h1;
   localparam logic [3:0] BP_OFS_LATCH      = 4'h2;
   localparam logic [3:0] BP_OFS_ANALOG     = 4'h3;
   localparam logic [3:0] BP_OFS_PULLUP     = 4'h4;
   localparam logic [3:0] BP_OFS_OPEN_DRAIN = 4'h5;
   localparam logic [3:0] BP_OFS_SLEW       = 4'h6;
   localparam logic [3:0] BP_OFS_THRESHOLD  = 4'h7;
   // reset values
   localparam logic [7:0] BP_RST_DIRECTION  = 8'hFF;
   localparam logic [7:0] BP_RST_LATCH      = 8'h00;
   localparam logic [7:0] BP_RST_ANALOG     = 8'hFF;
   localparam logic [7:0] BP_RST_PULLUP     = 8'h00;
   localparam logic [7:0] BP_RST_OPEN_DRAIN = 8'h00;
   localparam logic [7:0] BP_RST_SLEW       = 8'hFF;
   localparam logic [7:0] BP_RST_THRESHOLD  = 8'hFF;
   localparam logic [7:0] BP_RD_UNMAPPED    = 8'h00;
   // per-pin output source select
   typedef enum logic [1:0] {
      BP_SRC_LATCH = 2'b00,
      BP_SRC_PERIPH = 2'b01,
      BP_SRC_ANALOG = 2'b11
   } bp_src_t;
endpackage : bp_pkg

// ---- rtl/bp_sync_if.sv ----
// interface: synchroniser carrying raw pin levels into the clock domain
`timescale 1ns/1ns
interface bp_sync_if #(parameter int unsigned WIDTH = 8);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] synced;
   modport owner (output raw, input synced);
   modport sync  (input raw, output synced);
endinterface : bp_sync_if

// ---- rtl/bp_sync.sv ----
// module: two-stage synchroniser for the pin inputs
`timescale 1ns/1ns
module bp_sync #(
   parameter int unsigned WIDTH = 8
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   // pins
   bp_sync_if.sync   port
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   always_comb begin
      meta_next = port.raw;
      sync_next = meta_reg;
   end

   // first stage feeds only the second
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign port.synced = sync_reg;
endmodule : bp_sync

// ---- rtl/bp_port_bank.sv ----
// module: eight-pin bidirectional general purpose io port bank
//
// How it works
// - eight pins; direction 1 disables driver, 0 drives the output latch
// - pin-level read returns sampled pins; write goes into output latch
// - latch write equals pin-level write; latch read returns latch contents
// - latch holds the most recent write through either register
// - port writes store the written byte whole into the latch; pins are not read
// - analog-selected pins read as zero in every digital read
// - analog select does not touch digital output driving
// - analog select bits reset to analog mode
// - enabled analog output overrides all digital drive, pin released
// - after reset the output source is the latch
// - enabled peripheral takes the drive; pin level stays readable
// - per-pin open-drain: pull low only, release for high
// - serial-bus peripheral makes its pins open-drain by itself
// - per-pin slew-limit bit passed to the pad
// - per-pin threshold select applies to reads and change detection
// - per-pin weak pull-up enable bit
// - pull-up forced off while the pin is an output
`timescale 1ns/1ns
module bp_port_bank
   import bp_pkg::*;
#(
   parameter int unsigned WIDTH = BP_WIDTH
) (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   // register port
   input  wire logic [BP_ADDR_W-1:0] addr_i,
   input  wire logic [7:0]           wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output logic      [7:0]           rdata_o,
   // pad inputs: schmitt and ttl receivers
   input  wire logic [WIDTH-1:0]     pad_st_i,
   input  wire logic [WIDTH-1:0]     pad_ttl_i,
   // peripheral and analog output sources
   input  wire logic [WIDTH-1:0]     periph_en_i,
   input  wire logic [WIDTH-1:0]     periph_out_i,
   input  wire logic [WIDTH-1:0]     periph_od_i,
   input  wire logic [WIDTH-1:0]     analog_out_en_i,
   // pad controls
   output logic      [WIDTH-1:0]     pad_out_o,
   output logic      [WIDTH-1:0]     pad_oe_b_o,
   output logic      [WIDTH-1:0]     pad_pullup_o,
   output logic      [WIDTH-1:0]     pad_slew_o,
   output logic      [WIDTH-1:0]     pad_ibuf_en_o,
   // synchronised digital levels for change detection
   output logic      [WIDTH-1:0]     pin_level_o
);
   // ********************************************************
   // input path
   // ********************************************************
   logic [WIDTH-1:0] thr_reg;
   logic [WIDTH-1:0] ana_reg;
   bp_sync_if #(.WIDTH(WIDTH)) sync_bus ();

   // threshold chosen before sync so reads and change detection agree
   assign sync_bus.raw = (thr_reg & pad_st_i) | (~thr_reg & pad_ttl_i);

   bp_sync #(.WIDTH(WIDTH)) u_sync (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .port    (sync_bus)
   );

   logic [WIDTH-1:0] level_dig;
   assign level_dig = sync_bus.synced & ~ana_reg;

   // ********************************************************
   // register file
   // ********************************************************
   logic [WIDTH-1:0] dir_reg,  dir_next;
   logic [WIDTH-1:0] lat_reg,  lat_next;
   logic [WIDTH-1:0] ana_next;
   logic [WIDTH-1:0] wpu_reg,  wpu_next;
   logic [WIDTH-1:0] odc_reg,  odc_next;
   logic [WIDTH-1:0] slr_reg,  slr_next;
   logic [WIDTH-1:0] thr_next;
   logic [7:0]       rdata_reg, rdata_next;

   always_comb begin
      dir_next   = dir_reg;
      lat_next   = lat_reg;
      ana_next   = ana_reg;
      wpu_next   = wpu_reg;
      odc_next   = odc_reg;
      slr_next   = slr_reg;
      thr_next   = thr_reg;
      rdata_next = BP_RD_UNMAPPED;
      if (wr_i) begin
         // byte write replaces every bit: read-modify-write merge is whole-word
         if (addr_i == BP_OFS_PIN_LEVEL || addr_i == BP_OFS_LATCH) begin
            lat_next = WIDTH'(wdata_i);
         end else if (addr_i == BP_OFS_DIRECTION) begin
            dir_next = WIDTH'(wdata_i);
         end else if (addr_i == BP_OFS_ANALOG) begin
            ana_next = WIDTH'(wdata_i);
         end else if (addr_i == BP_OFS_PULLUP) begin
            wpu_next = WIDTH'(wdata_i);
         end else if (addr_i == BP_OFS_OPEN_DRAIN) begin
            odc_next = WIDTH'(wdata_i);
         end else if (addr_i == BP_OFS_SLEW) begin
            slr_next = WIDTH'(wdata_i);
         end else if (addr_i == BP_OFS_THRESHOLD) begin
            thr_next = WIDTH'(wdata_i);
         end
      end
      if (rd_i) begin
         if (addr_i == BP_OFS_PIN_LEVEL) begin
            rdata_next = 8'(level_dig);
         end else if (addr_i == BP_OFS_LATCH) begin
            rdata_next = 8'(lat_reg);
         end else if (addr_i == BP_OFS_DIRECTION) begin
            rdata_next = 8'(dir_reg);
         end else if (addr_i == BP_OFS_ANALOG) begin
            rdata_next = 8'(ana_reg);
         end else if (addr_i == BP_OFS_PULLUP) begin
            rdata_next = 8'(wpu_reg);
         end else if (addr_i == BP_OFS_OPEN_DRAIN) begin
            rdata_next = 8'(odc_reg);
         end else if (addr_i == BP_OFS_SLEW) begin
            rdata_next = 8'(slr_reg);
         end else if (addr_i == BP_OFS_THRESHOLD) begin
            rdata_next = 8'(thr_reg);
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dir_reg   <= BP_RST_DIRECTION[WIDTH-1:0];
         lat_reg   <= BP_RST_LATCH[WIDTH-1:0];
         ana_reg   <= BP_RST_ANALOG[WIDTH-1:0];
         wpu_reg   <= BP_RST_PULLUP[WIDTH-1:0];
         odc_reg   <= BP_RST_OPEN_DRAIN[WIDTH-1:0];
         slr_reg   <= BP_RST_SLEW[WIDTH-1:0];
         thr_reg   <= BP_RST_THRESHOLD[WIDTH-1:0];
         rdata_reg <= BP_RD_UNMAPPED;
      end else begin
         dir_reg   <= dir_next;
         lat_reg   <= lat_next;
         ana_reg   <= ana_next;
         wpu_reg   <= wpu_next;
         odc_reg   <= odc_next;
         slr_reg   <= slr_next;
         thr_reg   <= thr_next;
         rdata_reg <= rdata_next;
      end
   end

   // ********************************************************
   // output drive, per pin
   // ********************************************************
   logic [WIDTH-1:0] out_next, oe_b_next, pu_next, ibuf_next;
   logic [WIDTH-1:0] out_reg,  oe_b_reg,  pu_reg,  slew_reg, ibuf_reg, lvl_reg;

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_pin
         bp_src_t src;
         logic    val;
         logic    od;
         logic    drive;
         always_comb begin
            if (analog_out_en_i[gi]) begin
               src = BP_SRC_ANALOG;
            end else if (periph_en_i[gi]) begin
               src = BP_SRC_PERIPH;
            end else begin
               src = BP_SRC_LATCH;
            end
            val   = 1'b0;
            od    = odc_reg[gi];
            drive = 1'b0;
            case (src)
               BP_SRC_LATCH: begin
                  val   = lat_reg[gi];
                  drive = ~dir_reg[gi];
               end
               BP_SRC_PERIPH: begin
                  val   = periph_out_i[gi];
                  od    = odc_reg[gi] | periph_od_i[gi];
                  drive = ~dir_reg[gi];
               end
               default: begin
                  drive = 1'b0;
               end
            endcase
            // open drain drives only lows, releases for high
            out_next[gi]  = val & ~od;
            oe_b_next[gi] = ~(drive & ~(od & val));
            pu_next[gi]   = wpu_reg[gi] & dir_reg[gi];
            ibuf_next[gi] = ~ana_reg[gi];
         end
      end
   endgenerate

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_reg  <= '0;
         oe_b_reg <= '1;
         pu_reg   <= '0;
         slew_reg <= BP_RST_SLEW[WIDTH-1:0];
         ibuf_reg <= '0;
         lvl_reg  <= '0;
      end else begin
         out_reg  <= out_next;
         oe_b_reg <= oe_b_next;
         pu_reg   <= pu_next;
         slew_reg <= slr_reg;
         ibuf_reg <= ibuf_next;
         lvl_reg  <= level_dig;
      end
   end

   assign rdata_o       = rdata_reg;
   assign pad_out_o     = out_reg;
   assign pad_oe_b_o    = oe_b_reg;
   assign pad_pullup_o  = pu_reg;
   assign pad_slew_o    = slew_reg;
   assign pad_ibuf_en_o = ibuf_reg;
   assign pin_level_o   = lvl_reg;

   // ********************************************************
   // assertions
   // ********************************************************
   a_latch_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_i && (addr_i == BP_OFS_PIN_LEVEL || addr_i == BP_OFS_LATCH)
      |=> lat_reg == WIDTH'($past(wdata_i)))
      else $error("latch not updated by port write");
   a_latch_readback: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rd_i && addr_i == BP_OFS_LATCH |=> rdata_o == 8'($past(lat_reg)))
      else $error("latch read wrong");
   a_analog_reads_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rd_i && addr_i == BP_OFS_PIN_LEVEL
      |=> (rdata_o & 8'($past(ana_reg))) == 8'h00)
      else $error("analog pin read nonzero");
   a_drive_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !dir_reg[0] && !periph_en_i[0] && !analog_out_en_i[0] && !odc_reg[0]
      |=> !pad_oe_b_o[0] && pad_out_o[0] == $past(lat_reg[0]))
      else $error("pin 0 not driving latch");
   a_input_released: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      dir_reg[1] |=> pad_oe_b_o[1])
      else $error("input pin driven");
   a_analog_out_wins: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      analog_out_en_i != '0
      |=> (pad_oe_b_o & $past(analog_out_en_i)) == $past(analog_out_en_i))
      else $error("analog output not released");
   a_open_drain_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      odc_reg[3] && lat_reg[3] && !periph_en_i[3] && !analog_out_en_i[3]
      |=> pad_oe_b_o[3])
      else $error("open drain drove high");
   a_serial_od: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      periph_en_i[4] && periph_od_i[4] && periph_out_i[4] && !analog_out_en_i[4]
      |=> pad_oe_b_o[4])
      else $error("serial pin drove high");
   a_pullup_output: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !dir_reg[5] |=> !pad_pullup_o[5])
      else $error("pull-up on output pin");
   // both stages must have left reset, else the zeroed first stage looks like a short path
   a_sync_delay: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $past(rst_b_i, 2) && $past(rst_b_i)
      |-> sync_bus.synced == $past(sync_bus.raw, 2))
      else $error("synchroniser depth wrong");
   a_analog_digital_out: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ana_reg[6] && !dir_reg[6] && !periph_en_i[6] && !analog_out_en_i[6]
      && !odc_reg[6] |=> !pad_oe_b_o[6])
      else $error("analog select blocked output");

   c_port_write: cover property (@(posedge clk_i) wr_i && addr_i == BP_OFS_PIN_LEVEL);
   c_periph_drive: cover property (@(posedge clk_i) periph_en_i[0] && !dir_reg[0]);
   c_analog_out: cover property (@(posedge clk_i) analog_out_en_i != '0);
   c_pin_read: cover property (@(posedge clk_i) rd_i && addr_i == BP_OFS_PIN_LEVEL);
endmodule : bp_port_bank

// ---- dv/bp_pin_model.sv ----
// partner model: pin wires with external drivers, pull-ups and both receivers
`timescale 1ns/1ns
module bp_pin_model (
   // pad controls from the bank
   input  wire logic [7:0] pad_out_i,
   input  wire logic [7:0] pad_oe_b_i,
   input  wire logic [7:0] pad_pullup_i,
   // external driver and mid-level marker
   input  wire logic [7:0] ext_en_i,
   input  wire logic [7:0] ext_val_i,
   input  wire logic [7:0] mid_i,
   // receiver outputs
   output logic      [7:0] st_o,
   output logic      [7:0] ttl_o
);
   // ***************************************************************
   // wire resolution
   // ***************************************************************
   // a floating pin flips on each change, so a stale value never reads as valid
   always @(pad_out_i or pad_oe_b_i or pad_pullup_i or ext_en_i or ext_val_i or mid_i) begin
      for (int i = 0; i < 8; i++) begin
         if (!pad_oe_b_i[i]) st_o[i] = pad_out_i[i];
         else if (ext_en_i[i]) st_o[i] = ext_val_i[i];
         else if (pad_pullup_i[i]) st_o[i] = 1'b1;
         else st_o[i] = (st_o[i] === 1'b1) ? 1'b0 : 1'b1;
      end
      // a mid-level voltage is judged differently by the two receivers
      ttl_o = st_o ^ mid_i;
   end
endmodule : bp_pin_model

// ---- dv/tb.sv ----
// testbench: register-port tests of the io port bank
`timescale 1ns/1ns
module tb;
   import bp_pkg::*;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
   // ***************************************************************
   // signals
   // ***************************************************************
   logic       clk_i = 1'b0;
   logic       rst_b_i = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] rdata, st, ttl, p_en, p_out, p_od, a_en, ext_en, ext_val, mid;
   logic [7:0] out, oe_b, pu, slew, ibuf, lvl;
   int         mismatches = 0;
   int         num_checks = 0;
   initial {p_en, p_out, p_od, a_en, mid} = '0;
   always #5 clk_i = ~clk_i;
   bp_port_bank dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pad_st_i(st), .pad_ttl_i(ttl),
      .periph_en_i(p_en), .periph_out_i(p_out), .periph_od_i(p_od),
      .analog_out_en_i(a_en), .pad_out_o(out), .pad_oe_b_o(oe_b), .pad_pullup_o(pu),
      .pad_slew_o(slew), .pad_ibuf_en_o(ibuf), .pin_level_o(lvl));
   bp_pin_model pin_u (.pad_out_i(out), .pad_oe_b_i(oe_b), .pad_pullup_i(pu),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .mid_i(mid), .st_o(st), .ttl_o(ttl));
   // ***************************************************************
   // bus tasks
   // ***************************************************************
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg
   // pads settle one edge after a write, pins need the synchroniser too
   task automatic settle();
      repeat (4) @(posedge clk_i);
      #1;
   endtask : settle
   task automatic test_end(input string name);
      $display("test %s done, mismatches so far %0d", name, mismatches);
   endtask : test_end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   // ***************************************************************
   // tests
   // ***************************************************************
   logic [7:0] v;
   logic [7:0] rst_tab [8] = '{8'h00, BP_RST_DIRECTION, BP_RST_LATCH, BP_RST_ANALOG,
      BP_RST_PULLUP, BP_RST_OPEN_DRAIN, BP_RST_SLEW, BP_RST_THRESHOLD};
   initial begin
      #200000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      ext_en = 8'hFF;
      ext_val = 8'h5A;
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      // reset values; pin read is zero because every pin starts analog
      for (int i = 0; i < 8; i++) begin
         rreg(i[3:0], v);
         `CHK(v, rst_tab[i])
      end
      settle();
      `CHK(oe_b, 8'hFF)
      `CHK(ibuf, 8'h00)
      `CHK(slew, BP_RST_SLEW)
      wreg(4'h8, 8'hAA);
      rreg(4'h8, v);
      `CHK(v, BP_RD_UNMAPPED)
      test_end("reset");
      // digital input with both thresholds, peripherals idle meanwhile
      wreg(BP_OFS_ANALOG, 8'h00);
      mid <= 8'hFF;
      settle();
      rreg(BP_OFS_PIN_LEVEL, v);
      `CHK(v, 8'h5A)
      `CHK(lvl, 8'h5A)
      wreg(BP_OFS_THRESHOLD, 8'h00);
      settle();
      rreg(BP_OFS_PIN_LEVEL, v);
      `CHK(v, 8'hA5)
      wreg(BP_OFS_THRESHOLD, 8'hFF);
      mid <= 8'h00;
      test_end("input");
      // pin-level and latch writes share the latch; one idle cycle between strobes
      wreg(BP_OFS_PIN_LEVEL, 8'h3C);
      rreg(BP_OFS_LATCH, v);
      `CHK(v, 8'h3C)
      wreg(BP_OFS_LATCH, 8'hC3);
      rreg(BP_OFS_LATCH, v);
      `CHK(v, 8'hC3)
      ext_en <= 8'h00;
      wreg(BP_OFS_PULLUP, 8'hFF);
      wreg(BP_OFS_DIRECTION, 8'h00);
      settle();
      `CHK(out, 8'hC3)
      `CHK(oe_b, 8'h00)
      `CHK(pu, 8'h00)
      rreg(BP_OFS_PIN_LEVEL, v);
      `CHK(v, 8'hC3)
      wreg(BP_OFS_DIRECTION, 8'hF0);
      settle();
      `CHK(pu, 8'hF0)
      wreg(BP_OFS_DIRECTION, 8'h00);
      test_end("latch");
      // analog select masks reads but leaves the driver alone
      wreg(BP_OFS_ANALOG, 8'hFF);
      settle();
      `CHK(oe_b, 8'h00)
      `CHK(ibuf, 8'h00)
      `CHK(lvl, 8'h00)
      rreg(BP_OFS_PIN_LEVEL, v);
      `CHK(v, 8'h00)
      wreg(BP_OFS_DIRECTION, 8'hFF);
      settle();
      `CHK(oe_b, 8'hFF)
      wreg(BP_OFS_DIRECTION, 8'h00);
      wreg(BP_OFS_ANALOG, 8'h00);
      test_end("analog");
      // open drain: high bits released, low bits pulled down
      wreg(BP_OFS_OPEN_DRAIN, 8'hFF);
      wreg(BP_OFS_LATCH, 8'hF8);
      settle();
      `CHK(oe_b, 8'hF8)
      `CHK(out, 8'h00)
      wreg(BP_OFS_OPEN_DRAIN, 8'h00);
      wreg(BP_OFS_LATCH, 8'h00);
      test_end("open_drain");
      // peripheral drive, serial-bus open drain, analog output override
      p_en <= 8'h1F;
      p_out <= 8'h15;
      settle();
      `CHK(out, 8'h15)
      rreg(BP_OFS_PIN_LEVEL, v);
      `CHK(v, 8'h15)
      p_od <= 8'h1F;
      settle();
      `CHK(oe_b, 8'h15)
      `CHK(out, 8'h00)
      a_en <= 8'h03;
      settle();
      `CHK(oe_b, 8'h17)
      wreg(BP_OFS_SLEW, 8'h00);
      settle();
      `CHK(slew, 8'h00)
      test_end("sources");
      report_and_stop();
   end
endmodule : tb
